// ==== include/prescaler_value_defines.svh ====
`ifndef PRESCALER_VALUE_DEFINES_SVH
`define PRESCALER_VALUE_DEFINES_SVH

// register offsets on the peripheral bus
`define PRESCALER_VALUE_OFS_CONTROL 16'hec00
`define PRESCALER_VALUE_OFS_PRESC_LOW 16'hec06
`define PRESCALER_VALUE_OFS_PRESC_HIGH 16'hec08
`define PRESCALER_VALUE_OFS_DIV_LOW 16'hec0a
`define PRESCALER_VALUE_OFS_DIV_HIGH 16'hec0c

// control bit positions
`define PRESCALER_VALUE_BIT_SWITCH_OFF 7
`define PRESCALER_VALUE_BIT_ALARM_EN 3
`define PRESCALER_VALUE_BIT_ALARM_REQ 2
`define PRESCALER_VALUE_BIT_TICK_EN 1
`define PRESCALER_VALUE_BIT_TICK_REQ 0

`define PRESCALER_VALUE_CONTROL_RESET 8'h00
`define PRESCALER_VALUE_PREDIV_RATIO 7'h40
`define PRESCALER_VALUE_PREDIV_LAST 6'h3f
`define PRESCALER_VALUE_DIV_WRAP 20'h00000
`define PRESCALER_VALUE_DIV_ONE 20'h00001
`define PRESCALER_VALUE_HIGH_WIDTH 4
`define PRESCALER_VALUE_LOW_WIDTH 16

`endif

// ==== include/prescaler_value_pkg.sv ====
package prescaler_value_pkg;

    // peripheral bus request toward the block
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [1:0] be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } prescaler_value_bus_req_t;

    typedef struct packed {
        logic switch_off;
        logic alarm_en;
        logic alarm_req;
        logic tick_en;
        logic tick_req;
    } prescaler_value_ctrl_t;

endpackage : prescaler_value_pkg

// ==== rtl/prescaler_value_timecount.sv ====
`timescale 1ns/1ps
`include "prescaler_value_defines.svh"

// 32-bit time counter and alarm compare, driven by the reference tick
module prescaler_value_timecount #(
    parameter int CW = 32
) (
    input wire logic clk,
    input wire logic tick,
    input wire logic load_time,
    input wire logic [CW-1:0] time_value,
    input wire logic load_alarm,
    input wire logic [CW-1:0] alarm_value,
    output logic [CW-1:0] count,
    output logic match
);
    typedef struct packed {
        logic [CW-1:0] count;
        logic [CW-1:0] alarm;
        logic match;
    } prescaler_value_tc_state_t;

    prescaler_value_tc_state_t s_r;
    prescaler_value_tc_state_t s_nxt;

    // not reset: timekeeping survives system reset
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.match = 1'b0;
        if (load_time)
        begin
            s_nxt.count = time_value;
        end
        else if (tick)
        begin
            s_nxt.count = s_r.count + 1'b1;
            s_nxt.match = ((s_r.count + 1'b1) == s_r.alarm);
        end
        if (load_alarm)
        begin
            s_nxt.alarm = alarm_value;
        end
    end

    always_ff @(posedge clk)
    begin
        s_r <= s_nxt;
    end

    assign count = s_r.count;
    assign match = s_r.match;
endmodule : prescaler_value_timecount

// ==== rtl/prescaler_value_top.sv ====
`timescale 1ns/1ps
`include "prescaler_value_defines.svh"

module prescaler_value_top
    import prescaler_value_pkg::*;
#(
    parameter int PW = 20
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // peripheral bus
    input wire prescaler_value_pkg::prescaler_value_bus_req_t BUS_REQ,
    output logic [15:0] BUS_RDATA,
    output logic BUS_RVALID,
    // time counter and alarm loading, power-down request
    input wire logic TIME_LOAD,
    input wire logic [31:0] TIME_VALUE,
    input wire logic ALARM_LOAD,
    input wire logic [31:0] ALARM_VALUE,
    input wire logic POWER_DOWN,
    // outputs
    output logic [31:0] TIME_COUNT,
    output logic TICK_INTERRUPT,
    output logic ALARM_INTERRUPT,
    output logic OSC_ENABLE,
    output logic REF_TICK
);
    import prescaler_value_pkg::*;

    typedef struct packed {
        prescaler_value_ctrl_t ctrl;
        logic [15:0] rdata;
        logic rvalid;
        logic tick_irq;
        logic alarm_irq;
        logic osc_en;
        logic ref_tick;
        logic [31:0] time_out;
    } prescaler_value_rst_state_t;

    // unreset timekeeping state
    typedef struct packed {
        logic [PW-1:0] presc;
        logic [PW-1:0] div;
        logic [5:0] prediv;
    } prescaler_value_keep_state_t;

    prescaler_value_rst_state_t s_r;
    prescaler_value_rst_state_t s_nxt;
    prescaler_value_keep_state_t k_r;
    prescaler_value_keep_state_t k_nxt;
    logic [31:0] count;
    logic match;
    logic tick;

    function automatic logic hit(input prescaler_value_bus_req_t r, input logic [15:0] ofs);
        hit = r.sel && (r.addr == ofs);
    endfunction : hit

    function automatic logic [15:0] merge(input logic [15:0] old, input prescaler_value_bus_req_t r);
        merge = {r.be[1] ? r.wdata[15:8] : old[15:8], r.be[0] ? r.wdata[7:0] : old[7:0]};
    endfunction : merge

    // tick is the wrap of the divider; combinational so counter and flag agree
    always_comb
    begin
        logic [15:0] w;
        logic [PW-1:0] pn;
        logic [PW-1:0] dinc;
        logic pw;
        w = 16'h0000;
        pw = 1'b0;
        pn = k_r.presc;
        dinc = k_r.div + `PRESCALER_VALUE_DIV_ONE;
        k_nxt = k_r;
        s_nxt = s_r;
        tick = 1'b0;
        s_nxt.rvalid = 1'b0;

        if (!s_r.ctrl.switch_off)
        begin
            k_nxt.prediv = k_r.prediv + 6'h01;
            if (k_r.prediv == `PRESCALER_VALUE_PREDIV_LAST)
            begin
                if (dinc == `PRESCALER_VALUE_DIV_WRAP)
                begin
                    k_nxt.div = k_r.presc;
                    tick = 1'b1;
                end
                else
                begin
                    k_nxt.div = dinc;
                end
            end
        end

        if (BUS_REQ.wr && s_r.ctrl.switch_off)
        begin
            if (hit(BUS_REQ, `PRESCALER_VALUE_OFS_PRESC_LOW))
            begin
                w = merge(k_r.presc[15:0], BUS_REQ);
                pn = {k_r.presc[PW-1:16], w};
                pw = 1'b1;
            end
            if (hit(BUS_REQ, `PRESCALER_VALUE_OFS_PRESC_HIGH) && BUS_REQ.be[0])
            begin
                pn = {BUS_REQ.wdata[3:0], k_r.presc[15:0]};
                pw = 1'b1;
            end
        end
        // immediate load
        // every accepted prescaler write reloads: unreset prescaler would compare unknown after power-up,
        // and the divider is stopped anyway while writes are open
        if (pw)
        begin
            k_nxt.presc = pn;
            k_nxt.div = pn;
            // restart predivider so the first period is exact
            k_nxt.prediv = '0;
        end

        // flag writes: zero clears, a set in the same cycle wins
        if (BUS_REQ.wr && hit(BUS_REQ, `PRESCALER_VALUE_OFS_CONTROL) && BUS_REQ.be[0])
        begin
            s_nxt.ctrl.switch_off = BUS_REQ.wdata[`PRESCALER_VALUE_BIT_SWITCH_OFF];
            s_nxt.ctrl.alarm_en = BUS_REQ.wdata[`PRESCALER_VALUE_BIT_ALARM_EN];
            s_nxt.ctrl.alarm_req = BUS_REQ.wdata[`PRESCALER_VALUE_BIT_ALARM_REQ];
            s_nxt.ctrl.tick_en = BUS_REQ.wdata[`PRESCALER_VALUE_BIT_TICK_EN];
            s_nxt.ctrl.tick_req = BUS_REQ.wdata[`PRESCALER_VALUE_BIT_TICK_REQ];
        end
        if (tick)
        begin
            s_nxt.ctrl.tick_req = 1'b1;
        end
        if (match)
        begin
            s_nxt.ctrl.alarm_req = 1'b1;
        end

        s_nxt.tick_irq = s_nxt.ctrl.tick_req && s_nxt.ctrl.tick_en;
        s_nxt.alarm_irq = s_nxt.ctrl.alarm_req && s_nxt.ctrl.alarm_en;
        s_nxt.osc_en = !(POWER_DOWN && s_r.ctrl.switch_off);
        s_nxt.ref_tick = tick;
        s_nxt.time_out = count;

        if (BUS_REQ.rd && BUS_REQ.sel)
        begin
            s_nxt.rvalid = 1'b1;
            unique case (BUS_REQ.addr)
                `PRESCALER_VALUE_OFS_CONTROL:
                    s_nxt.rdata = {8'h00, s_r.ctrl.switch_off, 3'h0, s_r.ctrl.alarm_en,
                        s_r.ctrl.alarm_req, s_r.ctrl.tick_en, s_r.ctrl.tick_req};
                `PRESCALER_VALUE_OFS_PRESC_LOW: s_nxt.rdata = k_r.presc[15:0];
                `PRESCALER_VALUE_OFS_PRESC_HIGH: s_nxt.rdata = {12'h000, k_r.presc[PW-1:16]};
                `PRESCALER_VALUE_OFS_DIV_LOW: s_nxt.rdata = k_r.div[15:0];
                `PRESCALER_VALUE_OFS_DIV_HIGH: s_nxt.rdata = {12'h000, k_r.div[PW-1:16]};
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // no reset on prescaler and divider
    always_ff @(posedge CORE_CLK)
    begin
        k_r <= k_nxt;
    end

    prescaler_value_timecount #(
        .CW(32)
    ) u_timecount (
        .clk(CORE_CLK),
        .tick(tick),
        .load_time(TIME_LOAD && s_r.ctrl.switch_off),
        .time_value(TIME_VALUE),
        .load_alarm(ALARM_LOAD),
        .alarm_value(ALARM_VALUE),
        .count(count),
        .match(match)
    );

    assign BUS_RDATA = s_r.rdata;
    assign BUS_RVALID = s_r.rvalid;
    assign TICK_INTERRUPT = s_r.tick_irq;
    assign ALARM_INTERRUPT = s_r.alarm_irq;
    assign OSC_ENABLE = s_r.osc_en;
    assign REF_TICK = s_r.ref_tick;
    assign TIME_COUNT = s_r.time_out;
endmodule : prescaler_value_top

// ==== test/prescaler_value_assertions.sv ====
`timescale 1ns/1ps
`include "prescaler_value_defines.svh"
module prescaler_value_chk
    import prescaler_value_pkg::*;
#(
    parameter int PW = 20
) (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire prescaler_value_pkg::prescaler_value_bus_req_t BUS_REQ,
    input wire logic [15:0] BUS_RDATA,
    input wire logic BUS_RVALID,
    input wire logic POWER_DOWN,
    input wire logic OSC_ENABLE,
    input wire logic REF_TICK
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    logic rd_q;
    logic mapped;
    logic [15:0] a;
    assign a = BUS_REQ.addr;
    assign rd_q = BUS_REQ.sel && BUS_REQ.rd;
    assign mapped = a inside {`PRESCALER_VALUE_OFS_CONTROL, `PRESCALER_VALUE_OFS_PRESC_LOW, `PRESCALER_VALUE_OFS_PRESC_HIGH,
        `PRESCALER_VALUE_OFS_DIV_LOW, `PRESCALER_VALUE_OFS_DIV_HIGH};
    chk_read_answer:
    assert property (rd_q |=> BUS_RVALID) else $error("read not answered");
    chk_no_stray:
    assert property (!rd_q |=> !BUS_RVALID) else $error("valid without read");
    chk_rdata_hold:
    assert property (!rd_q |=> $stable(BUS_RDATA)) else $error("read data moved");
    chk_unmapped_zero:
    assert property (rd_q && !mapped |=> BUS_RDATA == 16'h0000) else $error("unmapped read not zero");
    chk_high_zero:
    assert property (rd_q && (a == `PRESCALER_VALUE_OFS_PRESC_HIGH || a == `PRESCALER_VALUE_OFS_DIV_HIGH)
        |=> BUS_RDATA[15:4] == 12'h000) else $error("high bits not zero");
    chk_ctrl_unused:
    assert property (rd_q && a == `PRESCALER_VALUE_OFS_CONTROL |=> BUS_RDATA[15:8] == 8'h00
        && BUS_RDATA[6:4] == 3'h0) else $error("unused control bits set");
    chk_tick_gap:
    assert property (REF_TICK |=> (!REF_TICK)[*8]) else $error("ticks too close");
    chk_osc_run:
    assert property (!RESET && !POWER_DOWN |=> OSC_ENABLE) else $error("oscillator off while awake");
endmodule : prescaler_value_chk
bind prescaler_value_top prescaler_value_chk #(.PW(PW)) chk_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .BUS_REQ(BUS_REQ),
    .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID), .POWER_DOWN(POWER_DOWN),
    .OSC_ENABLE(OSC_ENABLE), .REF_TICK(REF_TICK));

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "prescaler_value_defines.svh"
module tb_top;
    import prescaler_value_pkg::*;
    localparam logic [15:0] ct = `PRESCALER_VALUE_OFS_CONTROL;
    localparam logic [15:0] pl = `PRESCALER_VALUE_OFS_PRESC_LOW;
    localparam logic [15:0] ph = `PRESCALER_VALUE_OFS_PRESC_HIGH;
    localparam logic [15:0] dl = `PRESCALER_VALUE_OFS_DIV_LOW;
    localparam logic [15:0] dh = `PRESCALER_VALUE_OFS_DIV_HIGH;
    logic CORE_CLK = 0, RESET = 1, TIME_LOAD = 0, ALARM_LOAD = 0, POWER_DOWN = 0;
    prescaler_value_bus_req_t BUS_REQ = '0;
    logic [31:0] TIME_VALUE = '0, ALARM_VALUE = 32'h2, TIME_COUNT;
    logic [15:0] BUS_RDATA;
    logic BUS_RVALID, TICK_INTERRUPT, ALARM_INTERRUPT, OSC_ENABLE, REF_TICK;
    int bad_count = 0, cmp_count = 0, cyc = 0, n = 0;
    prescaler_value_top dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
        .BUS_RVALID(BUS_RVALID), .TIME_LOAD(TIME_LOAD), .TIME_VALUE(TIME_VALUE), .ALARM_LOAD(ALARM_LOAD),
        .ALARM_VALUE(ALARM_VALUE), .POWER_DOWN(POWER_DOWN), .TIME_COUNT(TIME_COUNT),
        .TICK_INTERRUPT(TICK_INTERRUPT), .ALARM_INTERRUPT(ALARM_INTERRUPT), .OSC_ENABLE(OSC_ENABLE),
        .REF_TICK(REF_TICK));
    initial
    begin
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // whole run is a few thousand cycles
    always @(posedge CORE_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge CORE_CLK);
        BUS_REQ = '{1'b1, 1'b1, 1'b0, 2'h3, a, d};
        @(negedge CORE_CLK);
        BUS_REQ = '0;
    endtask : wr
    // answer is registered at the taking edge and checked at the next falling edge
    task automatic rdc(input logic [15:0] a, input logic [15:0] e, input string nm);
        @(negedge CORE_CLK);
        BUS_REQ = '{1'b1, 1'b0, 1'b1, 2'h3, a, 16'h0000};
        @(negedge CORE_CLK);
        BUS_REQ = '0;
        chk("rvalid", 32'h1, {31'h0, BUS_RVALID});
        chk(nm, {16'h0000, e}, {16'h0000, BUS_RDATA});
    endtask : rdc
    task automatic wtick();
        n = 0;
        do
        begin
            @(negedge CORE_CLK);
            n++;
        end
        while (REF_TICK !== 1'b1 && n < 2000);
    endtask : wtick
    initial
    begin
        repeat (20) @(negedge CORE_CLK);
        RESET = 0;
        rdc(ct, 16'h0000, "ctrl_reset");
        wr(ct, 16'h0080);
        wr(pl, 16'hfff0);
        wr(ph, 16'hffff);
        rdc(ph, 16'h000f, "presc_high");
        rdc(pl, 16'hfff0, "presc_low");
        rdc(dl, 16'hfff0, "div_loaded");
        wr(dl, 16'h1234);
        repeat (200) @(negedge CORE_CLK);
        rdc(dl, 16'hfff0, "div_stopped");
        rdc(dh, 16'h000f, "div_high");
        rdc(16'hec02, 16'h0000, "unmapped");
        POWER_DOWN = 1;
        repeat (2) @(negedge CORE_CLK);
        chk("osc_off", 32'h0, {31'h0, OSC_ENABLE});
        POWER_DOWN = 0;
        TIME_LOAD = 1;
        ALARM_LOAD = 1;
        @(negedge CORE_CLK);
        TIME_LOAD = 0;
        ALARM_LOAD = 0;
        wr(ct, 16'h000a);
        wr(pl, 16'h0000);
        rdc(pl, 16'hfff0, "presc_locked");
        wtick();
        // request state seen on interrupt outputs
        chk("tick_irq", 32'h1, {31'h0, TICK_INTERRUPT});
        wtick();
        chk("period", 32'h400, n);
        repeat (3) @(negedge CORE_CLK);
        chk("time", 32'h2, TIME_COUNT);
        chk("alarm_irq", 32'h1, {31'h0, ALARM_INTERRUPT});
        rdc(ct, 16'h000f, "ctrl_flags");
        wr(ct, 16'h0002);
        rdc(ct, 16'h0002, "ctrl_clear");
        chk("alarm_low", 32'h0, {31'h0, ALARM_INTERRUPT});
        wr(ct, 16'h0000);
        wtick();
        repeat (2) @(negedge CORE_CLK);
        chk("tick_masked", 32'h0, {31'h0, TICK_INTERRUPT});
        rdc(ct, 16'h0001, "tick_req");
        RESET = 1;
        repeat (2) @(negedge CORE_CLK);
        RESET = 0;
        rdc(ct, 16'h0000, "ctrl_again");
        rdc(pl, 16'hfff0, "presc_kept");
        end_sim();
    end
endmodule : tb_top
